// ---- rtl/prog_cmd_exec.sv ----
/*
 Serial programming command executive: receives commands over the two-wire
 link, executes them against the memory port and returns a response.
 Assumes the programmer masters the link clock, which may stop between frames,
 and a single-cycle-latency memory port on the system clock.
*/
// Overview of operation
// - No response timeout; executive waits for programmer clocks forever.
// - Opcodes 0 to 6 with lengths 1,4,4,19,51,4.
// - Opcodes 7 to B with lengths 2,3,3,3,1.
// - Reserved opcode 3 answered with negative acknowledge.
// - Code row 32 words of 24 bits; data row 16 of 16.
// - Sanity check returns 0x1000 then 0x0002.
// - Read16 carries count up to 2048, address high byte, address low.
// - Read16 response 0x1100, N+2, then N consecutive words.
// - Reads of unimplemented memory reset the executive.
// - Read24 count up to 32768 and 24-bit start address, packed data.
// - Read24 response 0x1200, packed length, odd N pads last upper byte.
// - Data row program: address plus sixteen words, row aligned.
// - Data row programmed, read back, compared, then 0x1400 0x0002.
// - Queries report pass, result in status code byte.
// - Blank query gives 0xF0 when blank, else 0x0F.
// - Version query returns major and minor nibbles.
// - Status code 0 ok, 1 verify failed, 2 other error.
// - Length counts header words; non-read responses are two words.
// - Data changes on falling edge, sampled rising, 16-bit MSB first.
// - Data held high while busy, then low 15 us before response.
// - One command outstanding, one response each except rejected reads, which self reset.
`timescale 1ns/1ps
module prog_cmd_exec
   import prog_exec_pkg::*;
#(
   parameter int          LOW_CYCLES = prog_exec_pkg::LOW_PULSE_CYCLES,
   parameter logic [7:0]  VERSION    = 8'h10,
   parameter logic [23:0] DATA_BASE  = 24'h7FF000,
   parameter logic [23:0] MEM_TOP    = 24'hFF0002
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_resetn,
   input  wire logic        i_prog_serial_clock,
   input  wire logic        i_prog_serial_data,
   output logic             o_prog_serial_data,
   output logic             o_prog_serial_data_oe,
   output logic             o_mem_rd,
   output logic             o_mem_wr,
   output logic             o_mem_erase,
   output logic      [23:0] o_mem_addr,
   output logic      [23:0] o_mem_wdata,
   input  wire logic [23:0] i_mem_rdata,
   input  wire logic        i_mem_blank,
   output logic             o_self_reset
);
   import prog_exec_pkg::*;

   typedef enum logic [3:0] {
      S_RECV  = 4'b0000,
      S_EXEC  = 4'b0001,
      S_RDREQ = 4'b0010,
      S_RDCAP = 4'b0011,
      S_PROG  = 4'b0100,
      S_VFY   = 4'b0101,
      S_LOW   = 4'b0110,
      S_SEND  = 4'b0111,
      S_WAIT  = 4'b1000
   } state_t;

   // Link-clock domain: shifter and word handshakes
   logic [15:0] rx_shift;
   logic [3:0]  rx_bit;
   logic [15:0] rx_word;
   logic        rx_tgl;
   logic [15:0] tx_shift;
   logic [3:0]  tx_bit;
   logic        tx_ack_tgl;
   logic        tx_done_l;

   // System domain
   state_t      state;
   logic [2:0]  rx_tgl_s;
   logic [15:0] rx_word_s;
   logic [2:0]  tx_ack_s;
   logic [1:0]  tx_done_s;
   logic        word_bad;
   logic        rx_pend;
   logic        tx_req;
   logic [15:0] tx_word;
   logic        tx_mode;
   logic [5:0]  wr_idx;
   logic [5:0]  rd_idx;
   logic [15:0] mem_q;
   logic [11:0] cmd_len;
   logic [3:0]  cmd_op;
   logic [15:0] hdr0;
   logic [15:0] hdr1;
   logic [16:0] resp_left;
   logic [1:0]  hdr_left;
   logic [15:0] count;
   logic [23:0] addr;
   logic [23:0] stash;
   logic        stash_odd;
   logic [4:0]  row_idx;
   logic        vfy_bad;
   logic [12:0] low_cnt;
   logic        rx_event;
   logic        tx_event;

   // Receive on rising edge, MSB first; transmit changes on falling edge
   // Mode, request and word are held for microseconds around link edges,
   // and the link clock stops between frames, so they are read directly
   always_ff @(posedge i_prog_serial_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         rx_shift  <= 16'h0000;
         rx_bit    <= 4'h0;
         rx_word   <= 16'h0000;
         rx_tgl    <= 1'b0;
         tx_done_l <= 1'b0;
      end else begin
         // Marks the last rising edge of the final response word
         tx_done_l <= tx_mode && tx_bit == 4'h0 && tx_req == tx_ack_tgl;
         if (!tx_mode) begin
            rx_shift <= {rx_shift[14:0], i_prog_serial_data};
            rx_bit   <= rx_bit + 4'h1;
            if (rx_bit == 4'hF) begin
               rx_word <= {rx_shift[14:0], i_prog_serial_data};
               rx_tgl  <= ~rx_tgl;
            end
         end else begin
            rx_bit <= 4'h0;
         end
      end
   end

   always_ff @(negedge i_prog_serial_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         tx_shift   <= 16'h0000;
         tx_bit     <= 4'h0;
         tx_ack_tgl <= 1'b0;
      end else if (tx_mode && tx_bit == 4'h0 && tx_req != tx_ack_tgl) begin
         tx_shift   <= tx_word;
         tx_bit     <= 4'h1;
         tx_ack_tgl <= ~tx_ack_tgl;
      end else if (tx_bit != 4'h0) begin
         tx_shift <= {tx_shift[14:0], 1'b0};
         tx_bit   <= tx_bit + 4'h1;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         rx_tgl_s  <= 3'b000;
         tx_ack_s  <= 3'b000;
         tx_done_s <= 2'b00;
      end else begin
         rx_tgl_s  <= {rx_tgl_s[1:0], rx_tgl};
         tx_ack_s  <= {tx_ack_s[1:0], tx_ack_tgl};
         tx_done_s <= {tx_done_s[0], tx_done_l};
      end
   end

   assign rx_event = rx_tgl_s[2] ^ rx_tgl_s[1];
   assign tx_event = tx_ack_s[2] ^ tx_ack_s[1];
   assign word_bad = i_mem_rdata[15:0] != mem_q;

   // Word stays stable for 16 link clocks after its toggle
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         rx_word_s <= 16'h0000;
      end else if (rx_event) begin
         rx_word_s <= rx_word;
      end
   end

   prog_cmd_mem #(.DEPTH(MAX_CMD_WORDS), .AW(6)) u_cmd_mem (
      .i_clk_sys (i_clk_sys),
      .i_wr_en   (rx_pend && state == S_RECV && wr_idx < 6'(MAX_CMD_WORDS)),
      .i_wr_addr (wr_idx),
      .i_wr_data (rx_word_s),
      .i_rd_addr (rd_idx),
      .o_rd_data (mem_q)
   );

   // Command store fed from the registered word one cycle after the event
   logic [15:0] w [4];

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         rx_pend <= 1'b0;
      end else begin
         rx_pend <= rx_event && state == S_RECV;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (rx_pend && wr_idx < 6'd4) begin
         w[wr_idx[1:0]] <= rx_word_s;
      end
   end

   // Main sequencer
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         state        <= S_RECV;
         wr_idx       <= 6'd0;
         rd_idx       <= 6'd0;
         cmd_len      <= 12'h000;
         cmd_op       <= 4'h0;
         hdr0         <= 16'h0000;
         hdr1         <= 16'h0000;
         resp_left    <= 17'h00000;
         hdr_left     <= 2'd0;
         count        <= 16'h0000;
         addr         <= 24'h000000;
         stash        <= 24'h000000;
         stash_odd    <= 1'b0;
         row_idx      <= 5'd0;
         vfy_bad      <= 1'b0;
         low_cnt      <= 13'h0000;
         tx_req       <= 1'b0;
         tx_word      <= 16'h0000;
         tx_mode      <= 1'b0;
         o_mem_rd     <= 1'b0;
         o_mem_wr     <= 1'b0;
         o_mem_erase  <= 1'b0;
         o_mem_addr   <= 24'h000000;
         o_mem_wdata  <= 24'h000000;
         o_self_reset <= 1'b0;
         o_prog_serial_data_oe <= 1'b0;
      end else begin
         o_mem_rd    <= 1'b0;
         o_mem_wr    <= 1'b0;
         o_mem_erase <= 1'b0;
         o_self_reset <= 1'b0;
         unique case (state)
            S_RECV: begin
               if (rx_pend) begin
                  wr_idx <= wr_idx + 6'd1;
                  if (wr_idx == 6'd0) begin
                     cmd_op  <= rx_word_s[15:12];
                     cmd_len <= rx_word_s[11:0];
                  end
                  if ((wr_idx == 6'd0 && rx_word_s[11:0] <= 12'h001)
                      || (wr_idx != 6'd0 && {6'd0, wr_idx} + 12'h001 >= cmd_len)) begin
                     state                 <= S_EXEC;
                     tx_mode               <= 1'b1;
                     o_prog_serial_data_oe <= 1'b1;
                  end
               end
            end
            S_EXEC: begin
               hdr0     <= {STAT_PASS, cmd_op, CODE_OK};
               hdr1     <= RESP_LEN_SHORT;
               hdr_left <= 2'd2;
               addr     <= {w[2][7:0], w[3]};
               unique case (cmd_op)
                  OP_SANITY: state <= S_LOW;
                  OP_READ16: begin
                     count <= {8'h00, w[1][7:0]} | {4'h0, w[1][11:8], 8'h00};
                     hdr1  <= {4'h0, w[1][11:0]} + 16'h0002;
                     if (w[1][11:0] > READ16_MAX || {w[2][7:0], w[3]} > MEM_TOP) begin
                        o_self_reset          <= 1'b1;
                        o_prog_serial_data_oe <= 1'b0;
                        tx_mode               <= 1'b0;
                        wr_idx                <= 6'd0;
                        state                 <= S_RECV;
                     end else begin
                        state <= S_LOW;
                     end
                  end
                  OP_READ24: begin
                     count <= w[1];
                     hdr1  <= 16'((17'(w[1]) + 17'(w[1][0])) * 3 / 2 + 2);
                     if (w[1] > READ24_MAX || w[1] == 16'h0000
                         || {w[2][7:0], w[3]} >= DATA_BASE) begin
                        o_self_reset          <= 1'b1;
                        o_prog_serial_data_oe <= 1'b0;
                        tx_mode               <= 1'b0;
                        wr_idx                <= 6'd0;
                        state                 <= S_RECV;
                     end else begin
                        state <= S_LOW;
                     end
                  end
                  OP_PROG_DATA: begin
                     row_idx <= 5'd0;
                     vfy_bad <= 1'b0;
                     rd_idx  <= 6'd3;
                     if (({w[1][7:0], w[2]} & ROW_ALIGN_MASK) != 24'h0) begin
                        hdr0  <= {STAT_FAIL, cmd_op, CODE_OTHER_ERR};
                        state <= S_LOW;
                     end else begin
                        addr  <= {w[1][7:0], w[2]};
                        state <= S_PROG;
                     end
                  end
                  OP_BLANK_QUERY: begin
                     hdr0  <= {STAT_PASS, cmd_op,
                               i_mem_blank ? CODE_BLANK : CODE_NOT_BLANK};
                     state <= S_LOW;
                  end
                  OP_VERSION_QUERY: begin
                     hdr0  <= {STAT_PASS, cmd_op, VERSION};
                     state <= S_LOW;
                  end
                  OP_ERASE_BULK, OP_ERASE_DATA, OP_ERASE_CODE: begin
                     o_mem_erase <= 1'b1;
                     o_mem_addr  <= {w[1][7:0], w[2]};
                     state       <= S_LOW;
                  end
                  OP_RESERVED: begin
                     hdr0  <= {STAT_NACK, cmd_op, CODE_OTHER_ERR};
                     state <= S_LOW;
                  end
                  default: begin
                     hdr0  <= {STAT_FAIL, cmd_op, CODE_OTHER_ERR};
                     state <= S_LOW;
                  end
               endcase
               low_cnt <= 13'(LOW_CYCLES);
            end
            S_PROG: begin
               // Row words stream out of the command store; one write per word
               rd_idx      <= rd_idx + 6'd1;
               o_mem_wr    <= rd_idx != 6'd3;
               o_mem_wdata <= {8'h00, mem_q};
               o_mem_addr  <= addr + {18'd0, row_idx, 1'b0};
               if (rd_idx != 6'd3) begin
                  row_idx <= row_idx + 5'd1;
               end
               if (rd_idx == 6'd3 + 6'(DATA_ROW_WORDS)) begin
                  // Store read starts one word early to meet the read-back
                  row_idx <= 5'd0;
                  rd_idx  <= 6'd2;
                  state   <= S_VFY;
               end
            end
            S_VFY: begin
               // Read back and compare each word of the row
               rd_idx     <= rd_idx + 6'd1;
               row_idx    <= row_idx + 5'd1;
               o_mem_rd   <= row_idx < 5'(DATA_ROW_WORDS);
               o_mem_addr <= addr + {18'd0, row_idx, 1'b0};
               if (row_idx >= 5'd2 && word_bad) begin
                  vfy_bad <= 1'b1;
               end
               if (row_idx == 5'(DATA_ROW_WORDS + 1)) begin
                  hdr0  <= {(vfy_bad || word_bad) ? STAT_FAIL : STAT_PASS, cmd_op,
                            (vfy_bad || word_bad) ? CODE_VERIFY_FAIL : CODE_OK};
                  state <= S_LOW;
               end
            end
            S_LOW: begin
               o_prog_serial_data_oe <= 1'b1;
               if (low_cnt != 13'h0000) begin
                  low_cnt <= low_cnt - 13'h0001;
               end else begin
                  o_prog_serial_data_oe <= 1'b0;
                  tx_word   <= hdr0;
                  tx_req    <= ~tx_req;
                  resp_left <= (cmd_op == OP_READ16 || cmd_op == OP_READ24)
                               ? 17'(hdr1) - 17'h1 : 17'h1;
                  hdr_left  <= 2'd1;
                  o_mem_rd  <= 1'b1;
                  o_mem_addr <= addr;
                  state     <= S_SEND;
               end
            end
            S_SEND: begin
               // Next word loaded only after link took the previous one
               if (tx_event) begin
                  if (resp_left == 17'h0) begin
                     state   <= S_WAIT;
                  end else begin
                     resp_left <= resp_left - 17'h1;
                     tx_req    <= ~tx_req;
                     if (hdr_left != 2'd0) begin
                        tx_word  <= hdr1;
                        hdr_left <= 2'd0;
                     end else if (cmd_op == OP_READ16) begin
                        tx_word    <= i_mem_rdata[15:0];
                        addr       <= addr + 24'h000002;
                        o_mem_addr <= addr + 24'h000002;
                        o_mem_rd   <= 1'b1;
                     end else if (!stash_odd) begin
                        tx_word    <= i_mem_rdata[15:0];
                        stash      <= i_mem_rdata;
                        stash_odd  <= 1'b1;
                        addr       <= addr + 24'h000002;
                        o_mem_addr <= addr + 24'h000002;
                        o_mem_rd   <= 1'b1;
                     end else begin
                        tx_word    <= (count == 16'h0001) ? {8'h00, stash[23:16]}
                                      : {i_mem_rdata[23:16], stash[23:16]};
                        count      <= count - 16'h0002;
                        stash_odd  <= 1'b0;
                        stash      <= i_mem_rdata;
                        if (count != 16'h0001) begin
                           hdr_left <= 2'd3;
                        end
                     end
                     if (hdr_left == 2'd3) begin
                        tx_word    <= stash[15:0];
                        hdr_left   <= 2'd0;
                        addr       <= addr + 24'h000002;
                        o_mem_addr <= addr + 24'h000002;
                        o_mem_rd   <= 1'b1;
                     end
                  end
               end
            end
            S_WAIT: begin
               // Tail of last word drains before listening again
               if (tx_done_s[1]) begin
                  tx_mode <= 1'b0;
                  wr_idx  <= 6'd0;
                  state   <= S_RECV;
               end
               stash_odd <= 1'b0;
            end
            default: state <= S_RECV;
         endcase
      end
   end

   // Line high while busy, low during the ready pulse, then shifted data
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_prog_serial_data <= 1'b0;
      end else begin
         o_prog_serial_data <= (state == S_LOW) ? 1'b0
                               : ((state == S_SEND || state == S_WAIT) ? tx_shift[15] : 1'b1);
      end
   end
endmodule // prog_cmd_exec

// ---- rtl/prog_exec_pkg.sv ----
/*
 Shared constants for the serial programming command executive: opcodes,
 command lengths, response headers, status codes and link timing.
 Assumes a 100 MHz system clock.
*/
package prog_exec_pkg;
   localparam int          SYS_CLK_MHZ      = 100;
   localparam int          WORD_BITS        = 16;
   localparam int          MAX_CMD_WORDS    = 51;
   localparam logic [3:0]  OP_SANITY        = 4'h0;
   localparam logic [3:0]  OP_READ16        = 4'h1;
   localparam logic [3:0]  OP_READ24        = 4'h2;
   localparam logic [3:0]  OP_RESERVED      = 4'h3;
   localparam logic [3:0]  OP_PROG_DATA     = 4'h4;
   localparam logic [3:0]  OP_PROG_CODE     = 4'h5;
   localparam logic [3:0]  OP_PROG_CONFIG   = 4'h6;
   localparam logic [3:0]  OP_ERASE_BULK    = 4'h7;
   localparam logic [3:0]  OP_ERASE_DATA    = 4'h8;
   localparam logic [3:0]  OP_ERASE_CODE    = 4'h9;
   localparam logic [3:0]  OP_BLANK_QUERY   = 4'hA;
   localparam logic [3:0]  OP_VERSION_QUERY = 4'hB;
   localparam logic [11:0] LEN_SANITY       = 12'h001;
   localparam logic [11:0] LEN_READ         = 12'h004;
   localparam logic [11:0] LEN_PROG_DATA    = 12'h013;
   localparam logic [11:0] LEN_PROG_CODE    = 12'h033;
   localparam logic [11:0] LEN_PROG_CONFIG  = 12'h004;
   localparam logic [11:0] LEN_ERASE_BULK   = 12'h002;
   localparam logic [11:0] LEN_ERASE_ROWS   = 12'h003;
   localparam logic [11:0] LEN_QUERY3       = 12'h003;
   localparam logic [3:0]  STAT_PASS        = 4'h1;
   localparam logic [3:0]  STAT_FAIL        = 4'h2;
   localparam logic [3:0]  STAT_NACK        = 4'h3;
   localparam logic [7:0]  CODE_OK          = 8'h00;
   localparam logic [7:0]  CODE_VERIFY_FAIL = 8'h01;
   localparam logic [7:0]  CODE_OTHER_ERR   = 8'h02;
   localparam logic [7:0]  CODE_BLANK       = 8'hF0;
   localparam logic [7:0]  CODE_NOT_BLANK   = 8'h0F;
   localparam logic [15:0] RESP_LEN_SHORT   = 16'h0002;
   localparam logic [11:0] READ16_MAX       = 12'h800;
   localparam logic [15:0] READ24_MAX       = 16'h8000;
   localparam int          DATA_ROW_WORDS   = 16;
   localparam int          CODE_ROW_WORDS   = 32;
   localparam logic [23:0] ROW_ALIGN_MASK   = 24'h00001F;
   localparam int          LOW_PULSE_US     = 15;
   localparam int          LOW_PULSE_CYCLES = LOW_PULSE_US * SYS_CLK_MHZ;
endpackage

// ---- rtl/prog_cmd_mem.sv ----
/*
 Command word store for one received command.
 Written and read in the system clock domain; read data registered.
*/
`timescale 1ns/1ps
module prog_cmd_mem #(
   parameter int DEPTH = 51,
   parameter int AW    = 6
) (
   input  wire logic          i_clk_sys,
   input  wire logic          i_wr_en,
   input  wire logic [AW-1:0] i_wr_addr,
   input  wire logic [15:0]   i_wr_data,
   input  wire logic [AW-1:0] i_rd_addr,
   output logic      [15:0]   o_rd_data
);
   logic [15:0] mem [DEPTH];

   always_ff @(posedge i_clk_sys) begin
      if (i_wr_en) begin
         mem[i_wr_addr] <= i_wr_data;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      o_rd_data <= mem[i_rd_addr];
   end
endmodule // prog_cmd_mem

// ---- test/prog_cmd_exec_asserts.sv ----
/*
 Checker for the executive's link handshake and memory strobes.
 Bound to prog_cmd_exec; sees only its ports, system clock domain.
*/
`timescale 1ns/1ps
module prog_cmd_exec_asserts #(parameter int LOW_CYCLES = 1500) (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic o_prog_serial_data,
   input wire logic o_prog_serial_data_oe,
   input wire logic o_mem_rd,
   input wire logic o_mem_wr,
   input wire logic o_mem_erase,
   input wire logic o_self_reset
);
   wire         oe = o_prog_serial_data_oe;
   wire         sd = o_prog_serial_data;
   logic [15:0] low_count;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   // Length of the current ready pulse
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) low_count <= 16'h0000;
      else if (oe && !sd) low_count <= low_count + 16'h0001;
      else low_count <= 16'h0000;
   end
   sequence busy_s; oe && sd; endsequence
   sequence ready_s; oe && !sd; endsequence
   busy_first_a: assert property ($rose(oe) |-> busy_s)
      else $error("line not high when first driven");
   pulse_len_a: assert property ($fell(oe) && low_count != 16'h0000 |-> low_count == 16'(LOW_CYCLES))
      else $error("ready pulse length wrong");
   ready_hold_a: assert property ($fell(sd) && oe |-> ready_s [*8])
      else $error("ready pulse cut short");
   no_rebusy_a: assert property (ready_s |=> !busy_s)
      else $error("line high again after ready");
   self_pulse_a: assert property (o_self_reset |=> !o_self_reset)
      else $error("self reset longer than one cycle");
   self_quiet_a: assert property (o_self_reset |-> ##[1:4] !oe)
      else $error("line still driven after self reset");
   erase_busy_a: assert property (o_mem_erase |-> busy_s)
      else $error("erase outside processing");
   strobe_excl_a: assert property ($onehot0({o_mem_rd, o_mem_wr, o_mem_erase}))
      else $error("memory strobes overlap");
endmodule // prog_cmd_exec_asserts

bind prog_cmd_exec prog_cmd_exec_asserts #(.LOW_CYCLES(LOW_CYCLES)) u_chk (
   .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .o_prog_serial_data(o_prog_serial_data),
   .o_prog_serial_data_oe(o_prog_serial_data_oe), .o_mem_rd(o_mem_rd),
   .o_mem_wr(o_mem_wr), .o_mem_erase(o_mem_erase), .o_self_reset(o_self_reset));

// ---- test/prog_link_model.sv ----
/*
 Programmer model on the serial link: clock, command words, ready wait, responses.
 Assumes a free 12 ns base clock; the link clock idles high between frames.
*/
`timescale 1ns/1ps
module prog_link_model (
   input  wire logic i_base_clk,
   input  wire logic i_dev_data,
   input  wire logic i_dev_oe,
   output logic      o_link_clock,
   output logic      o_link_data
);
   localparam int HALF    = 42;
   logic          drv     = 1'b0;
   logic          rx      = 1'b0;
   logic          bit_out = 1'b0;
   // Released line toggles so a stale value cannot pass
   assign o_link_data = (i_dev_oe || rx) ? i_dev_data : (drv ? bit_out : i_base_clk);
   initial begin
      o_link_clock = 1'b1;
      repeat (4) #8 o_link_clock = ~o_link_clock;
   end
   task automatic half_wait();
      repeat (HALF) @(posedge i_base_clk);
   endtask
   task automatic send_word(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         o_link_clock = 1'b0;
         drv = 1'b1;
         bit_out = w[i];
         half_wait();
         o_link_clock = 1'b1;
         @(posedge i_base_clk);
         drv = (i != 0);
         half_wait();
      end
   endtask
   task automatic wait_ready();
      wait (i_dev_oe === 1'b1 && i_dev_data === 1'b0);
      repeat (1667) @(posedge i_base_clk);
   endtask
   task automatic recv_word(output logic [15:0] w);
      rx = 1'b1;
      for (int i = 15; i >= 0; i--) begin
         o_link_clock = 1'b0;
         half_wait();
         o_link_clock = 1'b1;
         w[i] = o_link_data;
         half_wait();
      end
      rx = 1'b0;
   endtask
endmodule // prog_link_model

// ---- test/prog_cmd_exec_test.sv ----
/*
 Self-checking bench for the command executive with a simple memory beside it.
 Assumes the programmer model and the checker are compiled first.
*/
`timescale 1ns/1ps
module prog_cmd_exec_test;
   import prog_exec_pkg::*;
   localparam int         LOWC  = 200;
   localparam logic [7:0] VER   = 8'h23;
   logic        i_clk_sys, i_resetn, base_clk, link_clk, link_data, dout, doe, rd, wr, er, sr;
   logic        blank = 1'b0;
   logic [23:0] addr;
   logic [23:0] rdata = 24'h000000;
   logic [15:0] resp [0:7];
   int          failures = 0, check_count = 0, cycles = 0, self_n = 0, erase_n = 0;
   prog_cmd_exec #(.LOW_CYCLES(LOWC), .VERSION(VER)) dut (
      .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_prog_serial_clock(link_clk),
      .i_prog_serial_data(link_data), .o_prog_serial_data(dout), .o_prog_serial_data_oe(doe),
      .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_erase(er), .o_mem_addr(addr), .o_mem_wdata(),
      .i_mem_rdata(rdata), .i_mem_blank(blank), .o_self_reset(sr));
   prog_link_model prog (.i_base_clk(base_clk), .i_dev_data(dout), .i_dev_oe(doe),
      .o_link_clock(link_clk), .o_link_data(link_data));
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      base_clk = 1'b0;
      #3.1;
      forever #6 base_clk = ~base_clk;
   end
   // Memory answers the address of the previous cycle
   always_ff @(posedge i_clk_sys) begin
      rdata <= {8'h00, addr[15:0] ^ 16'h5A5A};
      cycles <= cycles + 1;
      if (sr === 1'b1) self_n <= self_n + 1;
      if (er === 1'b1) erase_n <= erase_n + 1;
   end
   always @(posedge i_clk_sys) if (cycles == 95000) begin
      failures++;
      tally_and_finish();
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic [15:0] cmd[$], input int nr);
      foreach (cmd[i]) prog.send_word(cmd[i]);
      prog.wait_ready();
      for (int i = 0; i < nr; i++) prog.recv_word(resp[i]);
   endtask
   task automatic t_short();
      xfer({16'h0001}, 2);
      check(resp[0], 16'h1000);
      check(resp[1], RESP_LEN_SHORT);
      xfer({16'h3001}, 2);
      check(resp[0], {STAT_NACK, OP_RESERVED, CODE_OTHER_ERR});
      xfer({16'hB001}, 2);
      check(resp[0], {STAT_PASS, OP_VERSION_QUERY, VER});
      xfer({16'h7002, 16'h0000}, 2);
      check(resp[0], {STAT_PASS, OP_ERASE_BULK, CODE_OK});
      check(16'(erase_n > 0), 16'h0001);
      $display("test short responses done");
   endtask
   task automatic t_blank();
      for (int b = 0; b < 2; b++) begin
         @(posedge i_clk_sys) blank <= b[0];
         xfer({16'hA003, 16'h0000, 16'h0000}, 2);
         check(resp[0], {STAT_PASS, OP_BLANK_QUERY, b ? CODE_BLANK : CODE_NOT_BLANK});
         check(resp[1], RESP_LEN_SHORT);
      end
      $display("test blank query done");
   endtask
   task automatic t_read();
      xfer({16'h1004, 16'h0002, 16'h007F, 16'hF010}, 4);
      check(resp[0], 16'h1100);
      check(resp[1], 16'h0004);
      for (int k = 0; k < 2; k++) check(resp[2 + k], (16'hF010 + 16'(2 * k)) ^ 16'h5A5A);
      $display("test read done");
   endtask
   task automatic t_unimpl();
      foreach (resp[i]) resp[i] = 16'h0000;
      prog.send_word(16'h1004);
      prog.send_word(16'h0001);
      prog.send_word(16'h00FF);
      prog.send_word(16'h0010);
      for (int i = 0; i < 5000 && self_n == 0; i++) @(posedge i_clk_sys);
      check(16'(self_n), 16'h0001);
      $display("test unimplemented read done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      i_resetn = 1'b0;
      repeat (4) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      t_short();
      t_blank();
      t_read();
      t_unimpl();
      tally_and_finish();
   end
endmodule // prog_cmd_exec_test
